// File: design/xtpt_top.sv
// Board connectivity test: five XOR trees over device pins with mode entry.
// Assumes tester pins are synchronous to clk_sys and pin pads sit outside.
`timescale 1ns/100ps
`include "xtpt_regs.svh"

module xtpt_top #(
    parameter int W1 = `XTPT_W1,
    parameter int W2 = `XTPT_W2,
    parameter int W3 = `XTPT_W3,
    parameter int W4 = `XTPT_W4,
    parameter int W5 = `XTPT_W5
) (
    // Clock and reset.
    input  wire logic                clk_sys,
    input  wire logic                srst,
    // Mode selection pins.
    input  wire xtpt_pkg::xtpt_seq_t mode_pins,
    // Tree inputs, taken from input and bidirectional pin receivers.
    input  wire logic [W1-1:0]       tree1_in,
    input  wire logic [W2-1:0]       tree2_in,
    input  wire logic [W3-1:0]       tree3_in,
    input  wire logic [W4-1:0]       tree4_in,
    input  wire logic [W5-1:0]       tree5_in,
    // Functional drive of the observation pins and of all other drivers.
    input  wire logic [7:0]          func_sba,
    input  wire logic                func_sba_oe,
    input  wire logic                func_sb_stb_n,
    input  wire logic                func_sb_stb_n_oe,
    input  wire logic                func_bidir_oe,
    // Pin drive after the test multiplexer.
    output logic [7:0]               pin_sba,
    output logic [7:0]               pin_sba_oe,
    output logic                     pin_sb_stb_n,
    output logic                     pin_sb_stb_n_oe,
    output logic                     pin_bidir_oe,
    // Mode status.
    output logic                     xor_mode,
    output logic                     tristate_mode
);
    import xtpt_pkg::*;

    // Refuse tree widths that the chain function cannot hold.
    if (W1 < 1 || W2 < 1 || W3 < 1 || W4 < 1 || W5 < 1 ||
        W1 > `XTPT_MAXW || W2 > `XTPT_MAXW || W3 > `XTPT_MAXW ||
        W4 > `XTPT_MAXW || W5 > `XTPT_MAXW) begin : g_width_check
        $error("xtpt_top: tree widths must lie between 1 and 64");
    end

    // Running parity of a chain; the chain starts from a constant zero.
    function automatic logic xtpt_chain(input logic [`XTPT_MAXW-1:0] v, input int n);
        logic acc;
        acc = 1'b0; // see RL2
        for (int k = 0; k < `XTPT_MAXW; k++) begin
            if (k < n) begin
                acc = acc ^ v[k]; // see RL1 RL7
            end
        end
        return acc;
    endfunction

    xtpt_mode_t mode;
    xtpt_mode_t next_mode;

    // Mode entry: arm code, repeated for any number of cycles, then tree or tristate code.
    always_comb begin
        next_mode = mode;
        unique case (mode)
            XTPT_FUNC: begin
                if (mode_pins == `XTPT_SEQ_ARM) begin
                    next_mode = XTPT_ARM; // see RL9
                end
            end
            XTPT_ARM: begin
                if (mode_pins == `XTPT_SEQ_XOR) begin
                    next_mode = XTPT_XOR; // see RL9
                end else if (mode_pins == `XTPT_SEQ_TRI) begin
                    next_mode = XTPT_TRI; // see RL9
                end else if (mode_pins != `XTPT_SEQ_ARM) begin
                    next_mode = XTPT_FUNC;
                end
            end
            XTPT_XOR, XTPT_TRI: begin
                if (mode_pins == `XTPT_SEQ_EXIT) begin
                    next_mode = XTPT_FUNC;
                end
            end
            default: next_mode = XTPT_FUNC;
        endcase
        if (srst) begin
            next_mode = XTPT_FUNC;
        end
    end

    always_ff @(posedge clk_sys) begin
        mode <= next_mode;
    end

    logic [4:0] par;
    logic [7:0] next_sba;
    logic [7:0] next_sba_oe;
    logic       next_stb_n;
    logic       next_stb_n_oe;
    logic       next_bidir_oe;
    logic       next_xor_mode;
    logic       next_tri_mode;

    // Tree results, observation multiplexing and driver control.
    // Pin drive follows the next mode, so it switches on the edge that sets the mode flags.
    always_comb begin
        par[0] = xtpt_chain(`XTPT_MAXW'(tree1_in), W1);
        par[1] = xtpt_chain(`XTPT_MAXW'(tree2_in), W2); // see RL12
        par[2] = xtpt_chain(`XTPT_MAXW'(tree3_in), W3); // see RL13
        par[3] = xtpt_chain(`XTPT_MAXW'(tree4_in), W4); // see RL14
        par[4] = xtpt_chain(`XTPT_MAXW'(tree5_in), W5); // see RL15
        next_xor_mode = (next_mode == XTPT_XOR);
        next_tri_mode = (next_mode == XTPT_TRI);
        next_sba      = func_sba; // see RL16
        next_sba_oe   = {8{func_sba_oe}};
        next_stb_n    = func_sb_stb_n;
        next_stb_n_oe = func_sb_stb_n_oe;
        next_bidir_oe = func_bidir_oe;
        if (next_mode == XTPT_XOR) begin
            next_sba                 = 8'h00;
            next_sba_oe              = 8'h00;
            next_sba[`XTPT_OBS_T1_B] = par[0]; // see RL3 RL6
            next_sba[`XTPT_OBS_T2]   = par[1]; // see RL12
            next_sba[`XTPT_OBS_T4]   = par[3]; // see RL14
            next_sba[`XTPT_OBS_T5]   = par[4]; // see RL15
            next_sba_oe[`XTPT_OBS_T1_B] = 1'b1;
            next_sba_oe[`XTPT_OBS_T2]   = 1'b1;
            next_sba_oe[`XTPT_OBS_T4]   = 1'b1;
            next_sba_oe[`XTPT_OBS_T5]   = 1'b1;
            next_stb_n    = par[2]; // see RL13
            next_stb_n_oe = 1'b1;
            next_bidir_oe = 1'b0; // see RL1
        end else if (next_mode == XTPT_TRI) begin
            next_sba_oe   = 8'h00; // see RL9
            next_stb_n_oe = 1'b0;
            next_bidir_oe = 1'b0;
        end
        if (srst) begin
            next_sba      = 8'h00;
            next_sba_oe   = 8'h00;
            next_stb_n    = 1'b1;
            next_stb_n_oe = 1'b0;
            next_bidir_oe = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        pin_sba         <= next_sba;
        pin_sba_oe      <= next_sba_oe;
        pin_sb_stb_n    <= next_stb_n;
        pin_sb_stb_n_oe <= next_stb_n_oe;
        pin_bidir_oe    <= next_bidir_oe;
        xor_mode        <= next_xor_mode;
        tristate_mode   <= next_tri_mode;
    end

    // Checks on the registered pin drive.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    logic in_xor;
    assign in_xor = (mode == XTPT_XOR) && (next_mode == XTPT_XOR);

    a_zero_in_zero: assert property (in_xor && tree1_in == '0 && tree2_in == '0 // see RL4
        |=> pin_sba[0] == 1'b0 && pin_sba[1] == 1'b0)
        else $error("all-zero tree inputs did not give zero outputs");

    a_tree1_parity: assert property (in_xor // see RL3
        |=> pin_sba[0] == ^$past(tree1_in) && pin_sba_oe[0])
        else $error("tree one output differs from input parity");

    a_tree2_parity: assert property (in_xor // see RL12
        |=> pin_sba[1] == ^$past(tree2_in))
        else $error("tree two output differs from input parity");

    a_tree3_parity: assert property (in_xor // see RL13
        |=> pin_sb_stb_n == ^$past(tree3_in) && pin_sb_stb_n_oe)
        else $error("tree three output differs from input parity");

    a_tree4_parity: assert property (in_xor // see RL14
        |=> pin_sba[2] == ^$past(tree4_in))
        else $error("tree four output differs from input parity");

    a_tree5_parity: assert property (in_xor // see RL15
        |=> pin_sba[4] == ^$past(tree5_in))
        else $error("tree five output differs from input parity");

    a_single_toggle: assert property (in_xor && $onehot(tree2_in ^ $past(tree2_in)) // see RL5
        ##1 in_xor |-> pin_sba[1] != $past(pin_sba[1]))
        else $error("single input change did not toggle tree two output");

    a_bidir_input: assert property (in_xor |=> !pin_bidir_oe) // see RL1
        else $error("bidirectional driver enabled during tree test");

    a_tri_all_off: assert property (mode == XTPT_TRI && next_mode == XTPT_TRI // see RL9
        |=> pin_sba_oe == 8'h00 && !pin_sb_stb_n_oe && !pin_bidir_oe)
        else $error("driver enabled in tristate mode");

    a_entry_xor: assert property (mode == XTPT_ARM && mode_pins == `XTPT_SEQ_XOR // see RL9
        |=> xor_mode && !tristate_mode && pin_sba_oe == 8'h17)
        else $error("tree mode not entered after entry sequence");

    a_func_pass: assert property (mode == XTPT_FUNC && next_mode != XTPT_XOR // see RL16
        |=> pin_sba == $past(func_sba) && pin_bidir_oe == $past(func_bidir_oe))
        else $error("functional pin drive altered outside test modes");

    a_entry_tri: assert property (mode == XTPT_ARM && mode_pins == `XTPT_SEQ_TRI // see RL9
        |=> tristate_mode && !xor_mode && pin_sba_oe == 8'h00 && !pin_bidir_oe)
        else $error("tristate mode not entered after entry sequence");

    a_exit_func: assert property ((mode == XTPT_XOR || mode == XTPT_TRI) // see RL16
        && mode_pins == `XTPT_SEQ_EXIT
        |=> !xor_mode && !tristate_mode && pin_sba == $past(func_sba)
        && pin_bidir_oe == $past(func_bidir_oe))
        else $error("functional pin drive not restored on test mode exit");

    c_enter_xor:  cover property (mode == XTPT_ARM ##1 mode == XTPT_XOR);
    c_enter_tri:  cover property (mode == XTPT_ARM ##1 mode == XTPT_TRI);
    c_odd_start:  cover property (in_xor && pin_sba[1] ##1 !pin_sba[1] ##1 pin_sba[1]);
    c_exit_test:  cover property (mode == XTPT_XOR ##1 mode == XTPT_FUNC);
    c_exit_tri:   cover property (mode == XTPT_TRI ##1 mode == XTPT_FUNC);

endmodule // xtpt_top

// File: design/xtpt_regs.svh
// Constants for the board connectivity (XOR tree) test block.
// Assumes a single 100 MHz system clock and synchronous tester pins.
// Summary of operation
// RL1: Each tree gate takes one pin; bidirectional pins act only as inputs.
// RL2: The first gate of every tree starts from a constant zero.
// RL3: Tree results reach observation outputs with no added inversion.
// RL4: All tree inputs at zero give a zero tree output.
// RL5: One input pulsed high then low makes the output follow.
// RL6: Pulsing a tree's first-gate pin drives that tree's observation output high then low.
// RL7: An odd count of stuck-high inputs starts outputs at one; pulses invert.
// RL8: Tester reads initial level, expects toggles, flags pins without toggle.
// RL9: Five mode pins in a fixed sequence select tree or tristate mode.
// RL10: Tester keeps complementary strobe pairs at opposite levels during testing.
// RL11: Tester runs the third and fourth trees one after the other.
// RL12: Tree two chains 58 inputs onto sideband address bit 1.
// RL13: Tree three chains 55 inputs onto the inverted sideband strobe.
// RL14: Tree four chains 18 inputs onto sideband address bit 2.
// RL15: Tree five chains 30 inputs onto sideband address bit 4.
// RL16: Outside test modes trees never affect functional pins or drivers.
`ifndef XTPT_REGS_SVH
`define XTPT_REGS_SVH

`define XTPT_W1        59
`define XTPT_W2        58
`define XTPT_W3        55
`define XTPT_W4        18
`define XTPT_W5        30
`define XTPT_MAXW      64

`define XTPT_OBS_T1    3
`define XTPT_OBS_T2    1
`define XTPT_OBS_T4    2
`define XTPT_OBS_T5    4
`define XTPT_OBS_T1_B  0

`define XTPT_SEQ_ARM   5'h15
`define XTPT_SEQ_XOR   5'h0a
`define XTPT_SEQ_TRI   5'h1f
`define XTPT_SEQ_EXIT  5'h00

`endif

// File: design/xtpt_pkg.sv
// Types for the board connectivity (XOR tree) test block.
// Assumes the constants header is included by the user of this package.
package xtpt_pkg;

    typedef enum logic [3:0] {
        XTPT_FUNC = 4'h1,
        XTPT_ARM  = 4'h2,
        XTPT_XOR  = 4'h4,
        XTPT_TRI  = 4'h8
    } xtpt_mode_t;

    typedef logic [4:0] xtpt_seq_t;

endpackage

// File: verif/xtpt_ate.sv
// Board tester model that sets the level seen at every tree input pin.
// Assumes the bench gives all pin drive and picks one tree under test.
`timescale 1ns/100ps
module xtpt_ate (
    // Tester drive, tree under test and pins that float high.
    input  wire logic [219:0] d_all,
    input  wire logic [2:0]   sel,
    input  wire logic [57:0]  stuck2,
    // Levels at the tree inputs.
    output logic [58:0]       tree1_in,
    output logic [57:0]       tree2_in,
    output logic [54:0]       tree3_in,
    output logic [17:0]       tree4_in,
    output logic [29:0]       tree5_in
);
    always_comb begin
        tree1_in = d_all[58:0];
        tree2_in = d_all[116:59] | stuck2;
        tree3_in = d_all[171:117];
        tree4_in = d_all[189:172];
        tree5_in = d_all[219:190];
        if (sel != 3'h4) begin
            tree4_in[2:0] = ~{tree3_in[46], tree3_in[21], tree3_in[9]};
            tree4_in[11] = ~tree3_in[54];
        end else if (sel == 3'h4) begin
            {tree3_in[46], tree3_in[21], tree3_in[9]} = ~tree4_in[2:0];
            tree3_in[54] = ~tree4_in[11];
        end
    end
endmodule // xtpt_ate

// File: verif/tb_top.sv
// Self-checking bench for the connectivity trees and their mode entry.
// Assumes the design package and the tester model are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
    import xtpt_pkg::*;
    logic               clk_sys = 0;
    logic               srst = 1;
    xtpt_seq_t          mode_pins = '0;
    logic [219:0]       d_all = '0;
    logic [2:0]         sel = '0;
    logic [57:0]        stuck2 = '0;
    logic [58:0]        tree1_in;
    logic [57:0]        tree2_in;
    logic [54:0]        tree3_in;
    logic [17:0]        tree4_in;
    logic [29:0]        tree5_in;
    logic [7:0]         func_sba = '0;
    logic               func_sba_oe = 0;
    logic               func_sb_stb_n = 0;
    logic               func_sb_stb_n_oe = 0;
    logic               func_bidir_oe = 0;
    logic [7:0]         pin_sba;
    logic [7:0]         pin_sba_oe;
    logic               pin_sb_stb_n;
    logic               pin_sb_stb_n_oe;
    logic               pin_bidir_oe;
    logic               xor_mode;
    logic               tristate_mode;
    int                 fail_count = 0;
    int                 samples_checked = 0;
    logic [41:0]        q[$];
    logic [41:0]        e;
    int                 lo[6] = '{0, 0, 59, 117, 172, 190};
    int                 hi[6] = '{0, 58, 116, 171, 189, 219};
    wire  [20:0]        obs = {pin_sba, pin_sba_oe, pin_sb_stb_n, pin_sb_stb_n_oe,
                               pin_bidir_oe, xor_mode, tristate_mode};

    xtpt_top xtpt_top_i (
        .clk_sys          (clk_sys),
        .srst             (srst),
        .mode_pins        (mode_pins),
        .tree1_in         (tree1_in),
        .tree2_in         (tree2_in),
        .tree3_in         (tree3_in),
        .tree4_in         (tree4_in),
        .tree5_in         (tree5_in),
        .func_sba         (func_sba),
        .func_sba_oe      (func_sba_oe),
        .func_sb_stb_n    (func_sb_stb_n),
        .func_sb_stb_n_oe (func_sb_stb_n_oe),
        .func_bidir_oe    (func_bidir_oe),
        .pin_sba          (pin_sba),
        .pin_sba_oe       (pin_sba_oe),
        .pin_sb_stb_n     (pin_sb_stb_n),
        .pin_sb_stb_n_oe  (pin_sb_stb_n_oe),
        .pin_bidir_oe     (pin_bidir_oe),
        .xor_mode         (xor_mode),
        .tristate_mode    (tristate_mode)
    );
    xtpt_ate xtpt_ate_i (
        .d_all    (d_all),
        .sel      (sel),
        .stuck2   (stuck2),
        .tree1_in (tree1_in),
        .tree2_in (tree2_in),
        .tree3_in (tree3_in),
        .tree4_in (tree4_in),
        .tree5_in (tree5_in)
    );

    always #5 clk_sys = ~clk_sys;

    // Expected pins with care mask: 0 functional, 1 tree mode, 2 tristate.
    function automatic logic [41:0] expect_of(int k);
        if (k == 1)
            return {8'h17, 8'hff, 5'h1f, 3'h0, ^tree5_in, 1'b0, ^tree4_in, ^tree2_in,
                    ^tree1_in, 8'h17, ^tree3_in, 4'ha};
        return {21'h1fffff, func_sba, {8{func_sba_oe & (k == 0)}}, func_sb_stb_n,
                func_sb_stb_n_oe & (k == 0), func_bidir_oe & (k == 0), 1'b0, k == 2};
    endfunction

    task step(xtpt_seq_t m, int k, logic [219:0] dv);
        @(negedge clk_sys);
        mode_pins = m;
        d_all = dv;
        {func_sba, func_sba_oe, func_sb_stb_n, func_sb_stb_n_oe, func_bidir_oe} =
            12'($urandom);
        #1;
        q.push_back(expect_of(k));
    endtask

    task run(int t);
        sel = 3'(t);
        step(5'h15, 0, '0);
        step(5'h0a, 1, '0);
        for (int i = lo[t]; i <= hi[t]; i++) begin
            step(5'h0a, 1, 220'(1) << i);
            step(5'h1f, 1, '0);
        end
        step(5'h00, 0, '0);
    endtask

    task results;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        #1;
        if (q.size() > 0) begin
            e = q.pop_front();
            `CHK(obs & e[41:21], e[20:0])
        end
    end

    initial begin
        void'($urandom(71154));
        repeat (5) @(negedge clk_sys);
        `CHK(obs, 21'h10)
        srst = 0;
        repeat (16) step(5'h00, 0, '0);
        step(5'h15, 0, '0);
        step(5'h03, 0, '0);
        step(5'h15, 0, '0);
        step(5'h15, 0, '0);
        step(5'h1f, 2, '0);
        step(5'h0a, 2, '1);
        step(5'h00, 0, '0);
        for (int t = 1; t <= 5; t++)
            run(t);
        stuck2 = 58'h7;
        run(2);
        step(5'h15, 0, '0);
        step(5'h0a, 1, '0);
        @(negedge clk_sys);
        srst = 1;
        q.push_back({21'h1fffff, 21'h10});
        @(negedge clk_sys);
        srst = 0;
        step(5'h0a, 0, '0);
        repeat (2) @(negedge clk_sys);
        results();
    end

    // The tests take about 610 cycles; this cuts a hang short.
    initial begin
        #20000;
        fail_count++;
        results();
    end
endmodule // tb_top
